// ==== hdl/pstr_regs.sv ====
// fault status byte and telemetry read registers of the command set
// How it works
// [R1] bit 7 latches when the power stage reports a fault, else reads 0.
// [R2] bit 6 latches when output is above 2.75V at startup, else reads 0.
// [R3] bits 5 to 3 always read zero.
// [R4] bit 2 latches on a reset-voltage fault, else reads 0.
// [R5] bit 1 latches on a minimum-output-voltage fault, else reads 0.
// [R6] bit 0 latches when an expected phase pulse is missing, else reads 0.
// [R7] code 88h reads the input voltage as a linear word.
// [R8] linear words hold a 5-bit exponent in 15:11 and 11-bit mantissa in 10:0.
// [R9] code 89h reads the input current as a linear word.
// [R10] code 8Bh reads the output voltage as a 16-bit identifier-format word.
// [R11] code D4h reads the same output voltage as a linear word.
// [R12] code 8Ch reads the output current as a linear word.
// [R13] code 8Dh reads the temperature as a linear word.
// [R14] the status byte is read with code 80h and resets to 00h.
// [R15] flags stay set until a fault clear or reset; host writes do nothing.
`timescale 1ns/1ps
module pstr_regs
(
    input wire logic clock, // 20 MHz system clock
    input wire logic rst_n, // async reset, active low
    input wire logic [7:0] cmd_code, // command code of the read
    input wire logic rd_strobe, // one-cycle read request
    input wire logic wr_strobe, // one-cycle write request, ignored
    input wire logic [15:0] wr_data, // write data, ignored
    input wire logic clear_faults, // fault clear pulse from command logic
    input wire logic power_stage_fault, // power stage fault level, async
    input wire logic prebias_fault, // startup over-voltage level, async
    input wire logic reset_voltage_fault, // reset-voltage fault level, async
    input wire logic min_voltage_fault, // minimum output fault level, async
    input wire logic phase_missing, // missing phase pulse level, async
    input wire logic [4:0] vin_exp, // input voltage exponent
    input wire logic [10:0] vin_man, // input voltage mantissa
    input wire logic [4:0] iin_exp, // input current exponent
    input wire logic [10:0] iin_man, // input current mantissa
    input wire logic [15:0] vout_vid, // output voltage, identifier format
    input wire logic [4:0] vout_exp, // output voltage exponent
    input wire logic [10:0] vout_man, // output voltage mantissa
    input wire logic [4:0] iout_exp, // output current exponent
    input wire logic [10:0] iout_man, // output current mantissa
    input wire logic [4:0] temp_exp, // temperature exponent
    input wire logic [10:0] temp_man, // temperature mantissa
    output logic [15:0] rd_data, // read data, registered
    output logic rd_valid, // read data valid pulse
    output logic rd_unsupported, // pulse: code not held here
    output logic [7:0] fault_status // live status byte
);
    // ---------------------------------------------------------------
    // fault flag latching
    // ---------------------------------------------------------------
    logic [pstr_pkg::NUM_FLAGS-1:0] raw_faults;
    logic [pstr_pkg::NUM_FLAGS-1:0] sync_faults;
    logic [pstr_pkg::NUM_FLAGS-1:0] flags;

    // flag order: phase, min, reset-voltage, prebias, power stage
    assign raw_faults = {power_stage_fault, prebias_fault, reset_voltage_fault,
        min_voltage_fault, phase_missing};

    // async fault levels pass two flops first
    pstr_sync2 #(.W(pstr_pkg::NUM_FLAGS)) u_sync
    (
        .clock(clock),
        .rst_n(rst_n),
        .async_in(raw_faults),
        .sync_out(sync_faults)
    );

    // one sticky latch per flag
    genvar gi;
    generate
        for (gi = 0; gi < pstr_pkg::NUM_FLAGS; gi++)
        begin : g_flag
            pstr_flag_latch u_latch
            (
                .clock(clock),
                .rst_n(rst_n),
                .set_in(sync_faults[gi]),
                .clear_in(clear_faults), // R15
                .flag(flags[gi])
            );
        end
    endgenerate

    // status byte assembly, unimplemented bits tied low
    logic [7:0] status_byte;
    always_comb
    begin
        status_byte = pstr_pkg::STATUS_RESET; // R3 R14
        status_byte[pstr_pkg::BIT_PSTAGE] = flags[4]; // R1
        status_byte[pstr_pkg::BIT_PREBIAS] = flags[3]; // R2
        status_byte[pstr_pkg::BIT_RSTV] = flags[2]; // R4
        status_byte[pstr_pkg::BIT_VMIN] = flags[1]; // R5
        status_byte[pstr_pkg::BIT_PHASE] = flags[0]; // R6
    end
    assign fault_status = status_byte;

    // ---------------------------------------------------------------
    // telemetry words and read decode
    // ---------------------------------------------------------------
    logic [15:0] vin_word;
    logic [15:0] iin_word;
    logic [15:0] vout_lin_word;
    logic [15:0] iout_word;
    logic [15:0] temp_word;

    // linear packing: exponent high, mantissa low
    assign vin_word = {vin_exp, vin_man}; // R8
    assign iin_word = {iin_exp, iin_man}; // R8
    assign vout_lin_word = {vout_exp, vout_man}; // R8
    assign iout_word = {iout_exp, iout_man}; // R8
    assign temp_word = {temp_exp, temp_man}; // R8

    // command decode
    logic hit_status;
    logic hit_vin;
    logic hit_iin;
    logic hit_vvid;
    logic hit_iout;
    logic hit_temp;
    logic hit_vlin;
    logic hit_any;
    assign hit_status = cmd_code == pstr_pkg::CMD_FAULT_STATUS; // R14
    assign hit_vin = cmd_code == pstr_pkg::CMD_VIN; // R7
    assign hit_iin = cmd_code == pstr_pkg::CMD_IIN; // R9
    assign hit_vvid = cmd_code == pstr_pkg::CMD_VOUT_VID; // R10
    assign hit_iout = cmd_code == pstr_pkg::CMD_IOUT; // R12
    assign hit_temp = cmd_code == pstr_pkg::CMD_TEMP; // R13
    assign hit_vlin = cmd_code == pstr_pkg::CMD_VOUT_LIN; // R11
    assign hit_any = hit_status | hit_vin | hit_iin | hit_vvid | hit_iout
        | hit_temp | hit_vlin;

    // read mux, zero for codes not held here
    logic [15:0] rd_mux;
    assign rd_mux = hit_status ? {8'h00, status_byte} :
        hit_vin ? vin_word : // R7
        hit_iin ? iin_word : // R9
        hit_vvid ? vout_vid : // R10
        hit_iout ? iout_word : // R12
        hit_temp ? temp_word : // R13
        hit_vlin ? vout_lin_word : // R11
        pstr_pkg::WORD_RESET;

    // write port is accepted and dropped: every register here is read-only
    logic wr_unused;
    assign wr_unused = wr_strobe & (|wr_data); // R15

    // registered read answer, one cycle after the strobe
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_data <= pstr_pkg::WORD_RESET;
            rd_valid <= 1'b0;
            rd_unsupported <= 1'b0;
        end
        else
        begin
            rd_valid <= rd_strobe;
            rd_unsupported <= rd_strobe & ~hit_any;
            if (rd_strobe)
                rd_data <= rd_mux;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    sequence s_stage_fault;
        power_stage_fault ##2 1'b1;
    endsequence

    pstage_latch_a: assert property (@(posedge clock) disable iff (!rst_n) // R1
        s_stage_fault |=> fault_status[pstr_pkg::BIT_PSTAGE])
        else $error("power stage flag not set");
    prebias_latch_a: assert property (@(posedge clock) disable iff (!rst_n) // R2
        prebias_fault ##2 1'b1 |=> fault_status[pstr_pkg::BIT_PREBIAS])
        else $error("prebias flag not set");
    unused_zero_a: assert property (@(posedge clock) disable iff (!rst_n) // R3
        (fault_status & ~pstr_pkg::STATUS_IMPL_MASK) == 8'h00)
        else $error("unused status bits nonzero");
    rstv_latch_a: assert property (@(posedge clock) disable iff (!rst_n) // R4
        reset_voltage_fault ##2 1'b1 |=> fault_status[pstr_pkg::BIT_RSTV])
        else $error("reset voltage flag not set");
    vmin_latch_a: assert property (@(posedge clock) disable iff (!rst_n) // R5
        min_voltage_fault ##2 1'b1 |=> fault_status[pstr_pkg::BIT_VMIN])
        else $error("min voltage flag not set");
    phase_latch_a: assert property (@(posedge clock) disable iff (!rst_n) // R6
        phase_missing ##2 1'b1 |=> fault_status[pstr_pkg::BIT_PHASE])
        else $error("phase flag not set");
    vin_read_a: assert property (@(posedge clock) disable iff (!rst_n) // R7
        rd_strobe && cmd_code == pstr_pkg::CMD_VIN |=> rd_data == $past(vin_word))
        else $error("input voltage read wrong");
    lin_layout_a: assert property (@(posedge clock) disable iff (!rst_n) // R8
        rd_strobe && cmd_code == pstr_pkg::CMD_TEMP |=>
        rd_data[pstr_pkg::LIN_EXP_MSB:pstr_pkg::LIN_EXP_LSB] == $past(temp_exp)
        && rd_data[pstr_pkg::LIN_MAN_MSB:pstr_pkg::LIN_MAN_LSB] == $past(temp_man))
        else $error("linear layout wrong");
    iin_read_a: assert property (@(posedge clock) disable iff (!rst_n) // R9
        rd_strobe && cmd_code == pstr_pkg::CMD_IIN |=> rd_data == $past(iin_word))
        else $error("input current read wrong");
    vid_read_a: assert property (@(posedge clock) disable iff (!rst_n) // R10
        rd_strobe && cmd_code == pstr_pkg::CMD_VOUT_VID |=> rd_data == $past(vout_vid))
        else $error("vid read wrong");
    vlin_read_a: assert property (@(posedge clock) disable iff (!rst_n) // R11
        rd_strobe && cmd_code == pstr_pkg::CMD_VOUT_LIN |=>
        rd_data == $past(vout_lin_word))
        else $error("linear vout read wrong");
    iout_read_a: assert property (@(posedge clock) disable iff (!rst_n) // R12
        rd_strobe && cmd_code == pstr_pkg::CMD_IOUT |=> rd_data == $past(iout_word))
        else $error("output current read wrong");
    status_read_a: assert property (@(posedge clock) disable iff (!rst_n) // R14
        rd_strobe && cmd_code == pstr_pkg::CMD_FAULT_STATUS |=>
        rd_data == {8'h00, $past(status_byte)})
        else $error("status read wrong");
    flag_hold_a: assert property (@(posedge clock) disable iff (!rst_n) // R15
        $rose(fault_status[pstr_pkg::BIT_PHASE]) ##1 !clear_faults[*3] |->
        fault_status[pstr_pkg::BIT_PHASE])
        else $error("flag dropped without clear");

    // ---------------------------------------------------------------
    // read answer checks
    // ---------------------------------------------------------------
    // a read taken at this edge, by the kind of code it names
    sequence s_read_temp;
        rd_strobe && hit_temp;
    endsequence

    sequence s_read_known;
        rd_strobe && hit_any;
    endsequence

    sequence s_read_unknown;
        rd_strobe && !hit_any;
    endsequence

    // temperature word comes back whole
    temp_read_a: assert property (@(posedge clock) disable iff (!rst_n) // R13
        s_read_temp |=> rd_data == $past(temp_word))
        else $error("temperature read wrong");

    // every taken read is answered on the next edge
    valid_pulse_a: assert property (@(posedge clock) disable iff (!rst_n) // R14
        rd_strobe |=> rd_valid)
        else $error("read answer missing");

    // no answer without a request
    valid_idle_a: assert property (@(posedge clock) disable iff (!rst_n) // R14
        !rd_strobe |=> !rd_valid && !rd_unsupported)
        else $error("read answer without request");

    // read data holds between reads
    data_hold_a: assert property (@(posedge clock) disable iff (!rst_n) // R14
        !rd_strobe |=> $stable(rd_data))
        else $error("read data moved without a read");

    // codes held here are never refused
    known_code_a: assert property (@(posedge clock) disable iff (!rst_n) // R14
        s_read_known |=> !rd_unsupported)
        else $error("known code refused");

    // other codes answer zero and raise the refusal pulse
    unknown_code_a: assert property (@(posedge clock) disable iff (!rst_n) // R14
        s_read_unknown |=> rd_unsupported && rd_data == pstr_pkg::WORD_RESET)
        else $error("unknown code not refused");

    // outputs sit at their reset values one edge into reset
    reset_values_a: assert property (@(posedge clock) // R14
        !rst_n |=> !rd_valid && !rd_unsupported && rd_data == pstr_pkg::WORD_RESET
        && fault_status == pstr_pkg::STATUS_RESET)
        else $error("reset values wrong");

    // ---------------------------------------------------------------
    // flag hold and clear checks
    // ---------------------------------------------------------------
    // nothing arriving and nothing clearing
    sequence s_flags_quiet;
        !clear_faults && sync_faults == '0;
    endsequence

    // a clear with no fault arriving empties the byte
    clear_all_a: assert property (@(posedge clock) disable iff (!rst_n) // R15
        clear_faults && sync_faults == '0 |=> fault_status == pstr_pkg::STATUS_RESET)
        else $error("clear left a flag set");

    // a host write leaves the flags alone
    write_ignored_a: assert property (@(posedge clock) disable iff (!rst_n) // R15
        wr_unused ##0 s_flags_quiet |=> $stable(fault_status))
        else $error("write changed the status byte");

    // with nothing arriving and no clear the byte stays put
    flags_steady_a: assert property (@(posedge clock) disable iff (!rst_n) // R15
        s_flags_quiet |=> $stable(fault_status))
        else $error("status byte moved by itself");

    // a fault arriving in the same cycle as a clear keeps its flag
    set_wins_a: assert property (@(posedge clock) disable iff (!rst_n) // R6
        sync_faults[0] && clear_faults |=> fault_status[pstr_pkg::BIT_PHASE])
        else $error("clear beat an arriving phase fault");

    // the power stage flag outlives its cause
    pstage_hold_a: assert property (@(posedge clock) disable iff (!rst_n) // R1
        $rose(fault_status[pstr_pkg::BIT_PSTAGE]) ##1 !clear_faults[*3] |->
        fault_status[pstr_pkg::BIT_PSTAGE])
        else $error("power stage flag dropped without clear");

    // the reset-voltage flag outlives its cause
    rstv_hold_a: assert property (@(posedge clock) disable iff (!rst_n) // R4
        $rose(fault_status[pstr_pkg::BIT_RSTV]) ##1 !clear_faults[*3] |->
        fault_status[pstr_pkg::BIT_RSTV])
        else $error("reset voltage flag dropped without clear");
endmodule

// ==== hdl/pstr_pkg.sv ====
// shared constants for the status and telemetry register bank
package pstr_pkg;
    // command codes
    localparam logic [7:0] CMD_FAULT_STATUS = 8'h80;
    localparam logic [7:0] CMD_VIN = 8'h88;
    localparam logic [7:0] CMD_IIN = 8'h89;
    localparam logic [7:0] CMD_VOUT_VID = 8'h8b;
    localparam logic [7:0] CMD_IOUT = 8'h8c;
    localparam logic [7:0] CMD_TEMP = 8'h8d;
    localparam logic [7:0] CMD_VOUT_LIN = 8'hd4;
    // status byte layout
    localparam int BIT_PSTAGE = 7;
    localparam int BIT_PREBIAS = 6;
    localparam int BIT_RSTV = 2;
    localparam int BIT_VMIN = 1;
    localparam int BIT_PHASE = 0;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] STATUS_IMPL_MASK = 8'hc7;
    // linear word layout
    localparam int LIN_EXP_MSB = 15;
    localparam int LIN_EXP_LSB = 11;
    localparam int LIN_MAN_MSB = 10;
    localparam int LIN_MAN_LSB = 0;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam int NUM_FLAGS = 5;
endpackage

// ==== hdl/pstr_flag_latch.sv ====
// one sticky fault flag: set wins over clear
`timescale 1ns/1ps
module pstr_flag_latch
(
    input wire logic clock, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic set_in, // fault event, synchronised
    input wire logic clear_in, // fault clear command
    output logic flag // latched flag
);
    logic flag_next;

    // set beats clear in the same cycle
    assign flag_next = set_in | (flag & ~clear_in);

    // flag register
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            flag <= 1'b0;
        else
            flag <= flag_next;
    end
endmodule

// ==== hdl/pstr_sync2.sv ====
// two flip-flop synchroniser for a bus of levels
`timescale 1ns/1ps
module pstr_sync2 #(parameter int W = 1)
(
    input wire logic clock, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic [W-1:0] async_in, // levels from outside
    output logic [W-1:0] sync_out // synchronised levels
);
    logic [W-1:0] meta_reg;

    // first stage is read only by the second
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_reg <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule

// ==== bench/pstr_sense_model.sv ====
// sensing-side model: supplies telemetry words to the register bank
`timescale 1ns/1ps
module pstr_sense_model
(
    input wire logic clock, // system clock
    input wire logic load, // take a fresh set of readings
    output logic [95:0] tele = 96'h0 // six 16-bit words, vin word lowest
);
    // ----------------------------------------
    // new readings land just after the edge
    // ----------------------------------------
    always @(posedge clock)
    begin
        if (load)
            tele <= #1 {$urandom, $urandom, $urandom};
    end
endmodule

// ==== bench/tb_pstr_regs.sv ====
// self-checking bench for the status and telemetry register bank
`timescale 1ns/1ps
module tb_pstr_regs;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] cmd_code = 8'h00;
    logic rd_strobe = 1'b0;
    logic wr_strobe = 1'b0;
    logic [15:0] wr_data = 16'h0000;
    logic clear_faults = 1'b0;
    logic [4:0] fault_lv = 5'h00;
    logic load = 1'b0;
    logic [95:0] tele;
    logic [15:0] rd_data;
    logic rd_valid;
    logic rd_unsupported;
    logic [7:0] status_seen;
    logic [16:0] exp_q[$];
    logic [16:0] got;
    logic [7:0] flags;
    logic [7:0] codes[6];
    int pos[5];
    int n_errors = 0;
    int n_tests = 0;
    int cyc = 0;

    always #25 clock = ~clock;

    pstr_sense_model i_model (.clock(clock), .load(load), .tele(tele));

    pstr_regs i_dut (.clock(clock), .rst_n(rst_n), .cmd_code(cmd_code), .rd_strobe(rd_strobe),
        .wr_strobe(wr_strobe), .wr_data(wr_data), .clear_faults(clear_faults),
        .power_stage_fault(fault_lv[0]), .prebias_fault(fault_lv[1]),
        .reset_voltage_fault(fault_lv[2]), .min_voltage_fault(fault_lv[3]),
        .phase_missing(fault_lv[4]), .vin_exp(tele[15:11]), .vin_man(tele[10:0]),
        .iin_exp(tele[31:27]), .iin_man(tele[26:16]), .vout_vid(tele[47:32]),
        .vout_exp(tele[63:59]), .vout_man(tele[58:48]), .iout_exp(tele[79:75]),
        .iout_man(tele[74:64]), .temp_exp(tele[95:91]), .temp_man(tele[90:80]),
        .rd_data(rd_data), .rd_valid(rd_valid), .rd_unsupported(rd_unsupported),
        .fault_status(status_seen));

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // live status byte against the expected flags
    task automatic check_live(input logic [7:0] e);
        n_tests++;
        if (status_seen !== e)
        begin
            n_errors++;
            $display("ERROR fault_status expected %h seen %h", e, status_seen);
        end
    endtask

    // one read per cycle, strobe left high for back-to-back use
    task automatic rd(input logic [7:0] c, input logic [15:0] e, input logic u);
        @(posedge clock);
        #1;
        cmd_code = c;
        rd_strobe = 1'b1;
        exp_q.push_back({u, e});
    endtask

    task automatic idle(input int n);
        repeat (n)
        begin
            @(posedge clock);
            #1;
            rd_strobe = 1'b0;
            wr_strobe = 1'b0;
            clear_faults = 1'b0;
            load = 1'b0;
        end
    endtask

    // ----------------------------------------
    // monitor: oldest note against each answer
    // ----------------------------------------
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            n_errors++;
            $display("ERROR cycle_limit expected below 3000 seen %0d", cyc);
            give_verdict();
        end
        else if (rd_valid === 1'b1)
        begin
            got = (exp_q.size() > 0) ? exp_q.pop_front() : 17'h1ffff;
            n_tests++;
            if ({rd_unsupported, rd_data} !== got)
            begin
                n_errors++;
                $display("ERROR read_answer expected %h seen %h", got, {rd_unsupported, rd_data});
            end
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        codes = '{pstr_pkg::CMD_VIN, pstr_pkg::CMD_IIN, pstr_pkg::CMD_VOUT_VID,
            pstr_pkg::CMD_VOUT_LIN, pstr_pkg::CMD_IOUT, pstr_pkg::CMD_TEMP};
        pos = '{pstr_pkg::BIT_PSTAGE, pstr_pkg::BIT_PREBIAS, pstr_pkg::BIT_RSTV,
            pstr_pkg::BIT_VMIN, pstr_pkg::BIT_PHASE};
        void'($urandom(55577));
        repeat (16) @(posedge clock);
        #1;
        rst_n = 1'b1;
        for (int r = 0; r < 2; r++)
        begin
            rd(pstr_pkg::CMD_FAULT_STATUS, 16'h0000, 1'b0);
            load = 1'b1;
            idle(3);
            for (int k = 0; k < 6; k++)
                rd(codes[k], tele[k*16 +: 16], 1'b0);
            rd(8'h8a, 16'h0000, 1'b1);
            rd(8'h8e + 8'($urandom_range(7)), 16'h0000, 1'b1);
            idle(2);
        end
        flags = 8'h00;
        for (int i = 0; i < 5; i++)
        begin
            fault_lv[i] = 1'b1;
            idle(2);
            fault_lv[i] = 1'b0;
            idle(4);
            flags[pos[i]] = 1'b1;
            rd(pstr_pkg::CMD_FAULT_STATUS, {8'h00, flags}, 1'b0);
            idle(1);
        end
        check_live(8'hc7);
        @(posedge clock);
        #1;
        wr_strobe = 1'b1;
        wr_data = 16'hffff;
        idle(2);
        rd(pstr_pkg::CMD_FAULT_STATUS, 16'h00c7, 1'b0);
        clear_faults = 1'b1;
        idle(3);
        check_live(8'h00);
        rd(pstr_pkg::CMD_FAULT_STATUS, 16'h0000, 1'b0);
        fault_lv = 5'h1f;
        idle(5);
        @(posedge clock);
        #1;
        clear_faults = 1'b1;
        idle(2);
        check_live(8'hc7);
        fault_lv = 5'h00;
        rst_n = 1'b0;
        idle(3);
        rst_n = 1'b1;
        rd(pstr_pkg::CMD_FAULT_STATUS, 16'h0000, 1'b0);
        idle(4);
        check_live(8'h00);
        if (exp_q.size() != 0)
        begin
            n_errors++;
            $display("ERROR pending_reads expected 0 seen %0d", exp_q.size());
        end
        give_verdict();
    end
endmodule
